// *** rtl/rpc_pkg.sv ***
// package: constants and types of the power-up and nonvolatile config block
`default_nettype none
package rpc_pkg;
  localparam logic [5:0] ADDR_STATUS   = 6'h03;
  localparam logic [5:0] ADDR_NV_CFG   = 6'h30;
  localparam logic [5:0] ADDR_OFS_TRIM = 6'h31;
  localparam logic [5:0] ADDR_QUAD     = 6'h32;
  localparam logic [5:0] ADDR_TURNOVER = 6'h33;
  localparam logic [5:0] ADDR_RAM_BASE = 6'h38;
  localparam logic [5:0] ADDR_RAM_LAST = 6'h3f;
  // status bit positions
  localparam int ST_PON   = 5;
  localparam int ST_WARN  = 1;
  localparam int ST_CRIT  = 0;
  // nonvolatile config field positions
  localparam int CFG_TRICKLE_RES_80K_EN = 7;
  localparam int CFG_TRICKLE_RES_20K_EN = 6;
  localparam int CFG_R5K  = 5;
  localparam int CFG_R1K5 = 4;
  localparam int CFG_FDHI = 3;
  localparam int CFG_FDLO = 2;
  localparam int CFG_THE  = 1;
  localparam int CFG_THP  = 0;
  localparam int OFS_SIGN = 7;
  localparam logic [7:0] NV_CFG_RST   = 8'h02;
  localparam logic [7:0] TURNOVER_MSK = 8'h3f;
  // oscillator ticks, 32768 per second
  localparam int OSC_HZ           = 32768;
  localparam int SCAN_PERIOD_S    = 1;
  localparam int SCAN_SLOW_TICKS  = OSC_HZ * SCAN_PERIOD_S;
  localparam int SCAN_FAST_TICKS  = 32;
  localparam int TCNT_W           = 16;
  typedef enum {
    SQ_RESET, SQ_FAST_SCAN, SQ_NV_LOAD, SQ_TEMP_MEAS, SQ_RUN
  } rpc_seq_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rpc_req_t;
  typedef struct packed {
    rpc_seq_t          seq;
    logic [TCNT_W:0]   tick_cnt;
    logic              scan_req;
    logic              power_on_flag;
    logic              warn;
    logic              crit;
    logic [7:0]        nv_cfg;
    logic [7:0]        ofs_trim;
    logic [7:0]        quad;
    logic [7:0]        turnover;
    logic [63:0]       ram;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              nvw;
    logic [1:0]        nvw_idx;
    logic [7:0]        nvw_data;
    logic              nv_rd;
    logic [1:0]        nv_idx;
    logic              meas;
    logic              ready;
  } rpc_state_t;
endpackage
`default_nettype wire

// *** rtl/rpc_power_up_nv_config.sv ***
// power-up sequencer, nonvolatile config page and user scratch registers
// Functional notes
// - config bits 7..4 enable 80k, 20k, 5k, 1.5k trickle resistors.
// - config bits 3..2 select clock output frequency, all four codes valid.
// - config bit 1 enables thermometer, bit 0 selects measurement period.
// - offset trim holds sign bit 7, magnitude 0..121 in bits 6..0.
// - quadratic coefficient is an unsigned byte used by compensation.
// - turnover temperature in bits 5..0, range 4..67, bits 7..6 unused.
// - nonvolatile page is four registers: config plus three calibration.
// - eight volatile scratch bytes at 38h..3Fh, freely read and written.
// - backup mode disables serial port, clock output, trickle; interrupt stays.
// - trickle active only with a resistor selected and not on backup.
// - each low-supply flag may drive interrupt when its enable is set.
// - functions unmet by low supply are switched off automatically.
// - held in reset until supply valid, then registers take reset values.
// - power-on flag in status bit 5 set after reset, host clears by 0.
// - with oscillator running, voltage detector scans in fast mode.
// - supply above lower level ends fast scan and permits nonvolatile reads.
// - then nonvolatile page is copied in and both low flags cleared.
// - if thermometer enabled, measure and compute correction before running.
// - leaving fast scan, detector checks once per second.
// - warning flag set by a scan that finds supply below first level.
`default_nettype none
module rpc_power_up_nv_config
  import rpc_pkg::*;
#(
  parameter int SLOW_TICKS = SCAN_SLOW_TICKS,
  parameter int FAST_TICKS = SCAN_FAST_TICKS
) (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       SRST,
  // supply monitor and oscillator
  input  wire logic       SUPPLY_VALID,
  input  wire logic       OSC_RUNNING,
  input  wire logic       BACKUP_MODE,
  input  wire logic       BELOW_WARN_LEVEL,
  input  wire logic       BELOW_CRIT_LEVEL,
  input  wire logic       WARN_IRQ_EN,
  input  wire logic       CRIT_IRQ_EN,
  // serial register port
  input  wire rpc_req_t   REG_REQ,
  output var  logic [7:0] REG_RDATA,
  output var  logic       REG_RVALID,
  // nonvolatile memory read port
  output var  logic       NV_RD_REQ,
  output var  logic [1:0] NV_RD_IDX,
  input  wire logic       NV_RD_VALID,
  input  wire logic [7:0] NV_RD_DATA,
  // nonvolatile write hand-off
  output var  logic       NV_WR_REQ,
  output var  logic [1:0] NV_WR_IDX,
  output var  logic [7:0] NV_WR_DATA,
  // temperature measurement
  output var  logic       TEMP_MEAS_REQ,
  input  wire logic       TEMP_MEAS_DONE,
  // scan strobe and gated functions
  output var  logic       SCAN_STROBE,
  output var  logic [3:0] TRICKLE_RES_EN,
  output var  logic [1:0] CLOCK_OUTPUT_SEL,
  output var  logic       CLOCK_OUTPUT_EN,
  output var  logic       SERIAL_EN,
  output var  logic       THERMO_EN,
  output var  logic       TEMP_SCAN_PERIOD,
  output var  logic [7:0] OSC_OFFSET_TRIM,
  output var  logic [7:0] OSC_QUADRATIC_COEF,
  output var  logic [5:0] OSC_TURNOVER_TEMP,
  output var  logic       LOW_SUPPLY_IRQ,
  output var  logic       POWER_ON_FLAG,
  output var  logic       READY
);

  rpc_state_t s_reg;
  rpc_state_t s_next;
  logic       wr_ok;
  logic       rd_ok;
  logic       scan_due;

  localparam logic [TCNT_W:0] SLOW_LIM = (TCNT_W+1)'(SLOW_TICKS - 1);
  localparam logic [TCNT_W:0] FAST_LIM = (TCNT_W+1)'(FAST_TICKS - 1);

  always_comb begin
    s_next      = s_reg;
    s_next.rvalid = 1'b0;
    s_next.nvw  = 1'b0;
    s_next.scan_req = 1'b0;
    // backup level taken as already synchronised, no filter here
    wr_ok = REG_REQ.wr && !BACKUP_MODE && s_reg.seq != SQ_RESET;
    rd_ok = REG_REQ.rd && !BACKUP_MODE && s_reg.seq != SQ_RESET;
    scan_due = 1'b0;

    // detector scan timing; fast until the load starts
    if (s_reg.seq != SQ_RESET && OSC_RUNNING) begin
      if ((s_reg.seq == SQ_FAST_SCAN && s_reg.tick_cnt >= FAST_LIM) ||
          (s_reg.seq != SQ_FAST_SCAN && s_reg.tick_cnt >= SLOW_LIM)) begin
        s_next.tick_cnt = '0;
        scan_due        = 1'b1;
      end else begin
        s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
      end
    end
    s_next.scan_req = scan_due;

    // flags set on a scan below level; set beats host clear
    if (wr_ok && REG_REQ.addr == ADDR_STATUS) begin
      if (!REG_REQ.wdata[ST_PON])  s_next.power_on_flag  = 1'b0;
      if (!REG_REQ.wdata[ST_WARN]) s_next.warn = 1'b0;
      if (!REG_REQ.wdata[ST_CRIT]) s_next.crit = 1'b0;
    end
    if (scan_due && BELOW_WARN_LEVEL) s_next.warn = 1'b1;
    if (scan_due && BELOW_CRIT_LEVEL) s_next.crit = 1'b1;

    case (s_reg.seq)
      SQ_RESET: begin
        if (SUPPLY_VALID) begin
          s_next.seq = SQ_FAST_SCAN;
          s_next.power_on_flag = 1'b1;
        end
      end
      SQ_FAST_SCAN: begin
        if (scan_due && !BELOW_CRIT_LEVEL) begin
          s_next.seq      = SQ_NV_LOAD;
          s_next.tick_cnt = '0;
          s_next.nv_rd    = 1'b1;
          s_next.nv_idx   = 2'd0;
        end
      end
      SQ_NV_LOAD: begin
        if (NV_RD_VALID) begin
          case (s_reg.nv_idx)
            2'd0: s_next.nv_cfg   = NV_RD_DATA;
            2'd1: s_next.ofs_trim = NV_RD_DATA;
            2'd2: s_next.quad     = NV_RD_DATA;
            default: s_next.turnover = NV_RD_DATA & TURNOVER_MSK;
          endcase
          s_next.nv_idx = s_reg.nv_idx + 2'd1;
          if (s_reg.nv_idx == 2'd3) begin
            s_next.nv_rd = 1'b0;
            s_next.warn  = 1'b0;
            s_next.crit  = 1'b0;
            if (s_reg.nv_cfg[CFG_THE]) begin
              s_next.seq  = SQ_TEMP_MEAS;
              s_next.meas = 1'b1;
            end else begin
              s_next.seq   = SQ_RUN;
              s_next.ready = 1'b1;
            end
          end
        end
      end
      SQ_TEMP_MEAS: begin
        s_next.meas = 1'b0;
        if (TEMP_MEAS_DONE) begin
          s_next.seq   = SQ_RUN;
          s_next.ready = 1'b1;
        end
      end
      SQ_RUN: begin
        // working copy and hand-off for nonvolatile page writes
        if (wr_ok && REG_REQ.addr >= ADDR_NV_CFG &&
            REG_REQ.addr <= ADDR_TURNOVER) begin
          s_next.nvw      = 1'b1;
          s_next.nvw_idx  = REG_REQ.addr[1:0];
          s_next.nvw_data = REG_REQ.wdata;
          case (REG_REQ.addr[1:0])
            2'd0: s_next.nv_cfg   = REG_REQ.wdata;
            2'd1: s_next.ofs_trim = REG_REQ.wdata;
            2'd2: s_next.quad     = REG_REQ.wdata;
            default: s_next.turnover = REG_REQ.wdata & TURNOVER_MSK;
          endcase
        end
      end
      default: s_next.seq = SQ_RESET;
    endcase

    // scratch bytes usable in every state past reset
    if (wr_ok && REG_REQ.addr >= ADDR_RAM_BASE) begin
      s_next.ram[REG_REQ.addr[2:0]*8 +: 8] = REG_REQ.wdata;
    end
    if (rd_ok) begin
      s_next.rvalid = 1'b1;
      if (REG_REQ.addr >= ADDR_RAM_BASE)
        s_next.rdata = s_reg.ram[REG_REQ.addr[2:0]*8 +: 8];
      else if (REG_REQ.addr == ADDR_STATUS)
        s_next.rdata = {2'b00, s_reg.power_on_flag, 3'b000, s_reg.warn, s_reg.crit};
      else if (REG_REQ.addr == ADDR_NV_CFG)
        s_next.rdata = s_reg.nv_cfg;
      else if (REG_REQ.addr == ADDR_OFS_TRIM)
        s_next.rdata = s_reg.ofs_trim;
      else if (REG_REQ.addr == ADDR_QUAD)
        s_next.rdata = s_reg.quad;
      else if (REG_REQ.addr == ADDR_TURNOVER)
        s_next.rdata = s_reg.turnover;
      else
        s_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST || !SUPPLY_VALID) begin
      // every state register back to its reset value; output registers follow SRST only
      s_reg          <= '0;
      s_reg.seq      <= SQ_RESET;
      s_reg.nv_cfg   <= NV_CFG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs registered; gating also samples BACKUP_MODE and BELOW_WARN_LEVEL inputs, still no comb path out
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      REG_RDATA          <= 8'h00;
      REG_RVALID         <= 1'b0;
      NV_RD_REQ          <= 1'b0;
      NV_RD_IDX          <= 2'd0;
      NV_WR_REQ          <= 1'b0;
      NV_WR_IDX          <= 2'd0;
      NV_WR_DATA         <= 8'h00;
      TEMP_MEAS_REQ      <= 1'b0;
      SCAN_STROBE        <= 1'b0;
      TRICKLE_RES_EN     <= 4'h0;
      CLOCK_OUTPUT_SEL   <= 2'b00;
      CLOCK_OUTPUT_EN    <= 1'b0;
      SERIAL_EN          <= 1'b0;
      THERMO_EN          <= 1'b0;
      TEMP_SCAN_PERIOD   <= 1'b0;
      OSC_OFFSET_TRIM    <= 8'h00;
      OSC_QUADRATIC_COEF <= 8'h00;
      OSC_TURNOVER_TEMP  <= 6'h00;
      LOW_SUPPLY_IRQ     <= 1'b0;
      POWER_ON_FLAG      <= 1'b0;
      READY              <= 1'b0;
    end else begin
      REG_RDATA     <= s_next.rdata;
      REG_RVALID    <= s_next.rvalid;
      NV_RD_REQ     <= s_reg.nv_rd;
      NV_RD_IDX     <= s_reg.nv_idx;
      NV_WR_REQ     <= s_reg.nvw;
      NV_WR_IDX     <= s_reg.nvw_idx;
      NV_WR_DATA    <= s_reg.nvw_data;
      TEMP_MEAS_REQ <= s_reg.meas;
      SCAN_STROBE   <= s_reg.scan_req;
      // trickle off on backup or before ready, config applies otherwise
      TRICKLE_RES_EN <= (BACKUP_MODE || !s_reg.ready) ? 4'h0 :
                        s_reg.nv_cfg[CFG_TRICKLE_RES_80K_EN:CFG_R1K5];
      CLOCK_OUTPUT_SEL <= s_reg.nv_cfg[CFG_FDHI:CFG_FDLO];
      CLOCK_OUTPUT_EN  <= s_reg.ready && !BACKUP_MODE &&
                          !s_reg.crit;
      SERIAL_EN        <= s_reg.seq != SQ_RESET && !BACKUP_MODE;
      // thermometer needs the warning level met
      THERMO_EN        <= s_reg.nv_cfg[CFG_THE] &&
                          !BELOW_WARN_LEVEL;
      TEMP_SCAN_PERIOD <= s_reg.nv_cfg[CFG_THP];
      OSC_OFFSET_TRIM    <= s_reg.ofs_trim;
      OSC_QUADRATIC_COEF <= s_reg.quad;
      OSC_TURNOVER_TEMP  <= s_reg.turnover[5:0];
      // interrupt path kept alive in backup mode
      LOW_SUPPLY_IRQ <= (s_reg.warn && WARN_IRQ_EN) ||
                        (s_reg.crit && CRIT_IRQ_EN);
      POWER_ON_FLAG  <= s_reg.power_on_flag;
      READY          <= s_reg.ready;
    end
  end

  AST_PON_SET: assert property (@(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_RESET && SUPPLY_VALID) |=> s_reg.power_on_flag)
    else $error("power-on flag not set after reset release");
  AST_TRICKLE_BACKUP: assert property (@(posedge CLOCK) disable iff (SRST)
    BACKUP_MODE |=> TRICKLE_RES_EN == 4'h0)
    else $error("trickle left on in backup mode");
  AST_CLOCK_OUTPUT_BACKUP: assert property (@(posedge CLOCK) disable iff (SRST)
    BACKUP_MODE |=> !CLOCK_OUTPUT_EN && !SERIAL_EN)
    else $error("clock output or serial port on in backup");
  AST_FLAGS_CLEARED: assert property (@(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_NV_LOAD && NV_RD_VALID && s_reg.nv_idx == 2'd3)
    |=> !s_reg.warn && !s_reg.crit)
    else $error("low flags not cleared after load");
  AST_LOAD_AFTER_SCAN: assert property (@(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_FAST_SCAN && scan_due && !BELOW_CRIT_LEVEL)
    |=> s_reg.nv_rd ##1 NV_RD_REQ)
    else $error("nonvolatile read not started");
  AST_TEMP_BEFORE_RUN: assert property (@(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_TEMP_MEAS && !TEMP_MEAS_DONE) |=> !s_reg.ready)
    else $error("ready before temperature measured");
  AST_WARN_SET: assert property (@(posedge CLOCK) disable iff (SRST)
    (scan_due && BELOW_WARN_LEVEL && s_reg.seq != SQ_NV_LOAD)
    |=> s_reg.warn)
    else $error("warning flag missed");
  AST_SCAN_FAST: assert property (@(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_FAST_SCAN && s_reg.tick_cnt > FAST_LIM) |-> 1'b0)
    else $error("fast scan counter overran");
  AST_RAM_RW: assert property (@(posedge CLOCK) disable iff (SRST)
    (wr_ok && !rd_ok && REG_REQ.addr >= ADDR_RAM_BASE)
    ##1 (rd_ok && REG_REQ.addr == $past(REG_REQ.addr))
    |=> s_reg.rdata == $past(REG_REQ.wdata, 2))
    else $error("scratch byte read back wrong");

  // output side and internal state checks; each output but REG_RDATA and REG_RVALID lags its state by one edge
  AST_SERIAL_RESET: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_RESET) |=> !SERIAL_EN)
    else $error("serial port enabled while held in reset");
  AST_READ_ANSWER: assert property (
    @(posedge CLOCK) disable iff (SRST)
    rd_ok |=> REG_RVALID)
    else $error("accepted read gave no answer");
  AST_BACKUP_NO_READ: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (REG_REQ.rd && BACKUP_MODE) |=> !REG_RVALID)
    else $error("read answered in backup mode");
  AST_TRICKLE_CFG: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (s_reg.ready && !BACKUP_MODE)
    |=> TRICKLE_RES_EN == $past(s_reg.nv_cfg[CFG_TRICKLE_RES_80K_EN:CFG_R1K5]))
    else $error("trickle resistors differ from config");
  AST_CLKSEL_CFG: assert property (
    @(posedge CLOCK) disable iff (SRST)
    1'b1 |=> CLOCK_OUTPUT_SEL == $past(s_reg.nv_cfg[CFG_FDHI:CFG_FDLO]))
    else $error("clock output select differs from config");
  AST_THERMO_LOW: assert property (
    @(posedge CLOCK) disable iff (SRST)
    BELOW_WARN_LEVEL |=> !THERMO_EN)
    else $error("thermometer left on below warning level");
  AST_CRIT_CLOCK_OUTPUT: assert property (
    @(posedge CLOCK) disable iff (SRST)
    s_reg.crit |=> !CLOCK_OUTPUT_EN)
    else $error("clock output left on below critical level");
  AST_IRQ_BACKUP: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (BACKUP_MODE && s_reg.warn && WARN_IRQ_EN) |=> LOW_SUPPLY_IRQ)
    else $error("interrupt lost in backup mode");
  AST_IRQ_MASKED: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (!WARN_IRQ_EN && !CRIT_IRQ_EN) |=> !LOW_SUPPLY_IRQ)
    else $error("interrupt raised with both enables off");
  AST_TURN_UNUSED: assert property (
    @(posedge CLOCK) disable iff (SRST)
    s_reg.turnover[7:6] == 2'b00)
    else $error("turnover unused bits not zero");
  AST_NV_WR_RUN: assert property (
    @(posedge CLOCK) disable iff (SRST)
    s_reg.nvw |-> s_reg.seq == SQ_RUN)
    else $error("nonvolatile write handed off outside run");
  AST_PON_STICKY: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (s_reg.power_on_flag && SUPPLY_VALID &&
     !(wr_ok && REG_REQ.addr == ADDR_STATUS && !REG_REQ.wdata[ST_PON]))
    |=> s_reg.power_on_flag)
    else $error("power-on flag lost without host clear");
  AST_SLOW_SCAN: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_RUN && s_reg.tick_cnt > SLOW_LIM) |-> 1'b0)
    else $error("slow scan counter overran");
  AST_LOAD_IDX: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (s_reg.seq == SQ_NV_LOAD && NV_RD_VALID && s_reg.nv_idx != 2'd3)
    |=> s_reg.seq == SQ_NV_LOAD && s_reg.nv_rd)
    else $error("page load stopped before fourth byte");
  AST_READY_HOLD: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (s_reg.ready && SUPPLY_VALID) |=> s_reg.ready)
    else $error("ready dropped while supply valid");

endmodule
`default_nettype wire

// *** test/rpc_nv_model.sv ***
// nonvolatile page and thermometer stand-in for the config block
`default_nettype none
module rpc_nv_model
  import rpc_pkg::*;
#(
  parameter logic [31:0] PAGE = 32'hc4fff9a7
) (
  // clock, reset and response delay
  input  wire logic       CLOCK,
  input  wire logic       SRST,
  input  wire logic [3:0] DELAY,
  // page read
  input  wire logic       NV_RD_REQ,
  input  wire logic [1:0] NV_RD_IDX,
  output var  logic       NV_RD_VALID,
  output var  logic [7:0] NV_RD_DATA,
  // page write
  input  wire logic       NV_WR_REQ,
  input  wire logic [1:0] NV_WR_IDX,
  input  wire logic [7:0] NV_WR_DATA,
  // thermometer
  input  wire logic       TEMP_MEAS_REQ,
  output var  logic       TEMP_MEAS_DONE
);
  logic [7:0] page [4];
  logic [3:0] cnt;
  logic [3:0] tcnt;
  initial begin
    for (int i = 0; i < 4; i++) page[i] = PAGE[i*8 +: 8];
    NV_RD_DATA = 8'h5a;
  end
  always @(posedge CLOCK) begin
    NV_RD_VALID <= 1'b0;
    TEMP_MEAS_DONE <= 1'b0;
    // released data lines toggle so a stale byte never looks valid
    NV_RD_DATA <= ~NV_RD_DATA;
    if (SRST) begin
      cnt <= 4'h0;
      tcnt <= 4'h0;
    end else begin
      if (NV_RD_REQ && !NV_RD_VALID) begin
        if (cnt >= DELAY) begin
          NV_RD_VALID <= 1'b1;
          NV_RD_DATA <= page[NV_RD_IDX];
          cnt <= 4'h0;
        end else cnt <= cnt + 4'h1;
      end
      if (NV_WR_REQ) page[NV_WR_IDX] <= NV_WR_DATA;
      if (TEMP_MEAS_REQ) tcnt <= DELAY + 4'h1;
      else if (tcnt != 4'h0) begin
        tcnt <= tcnt - 4'h1;
        TEMP_MEAS_DONE <= (tcnt == 4'h1);
      end
    end
  end
endmodule
`default_nettype wire

// *** test/rpc_power_up_nv_config_test.sv ***
// self-checking bench of the power-up and nonvolatile config block
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module rpc_power_up_nv_config_test import rpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // short scan periods keep the run brief
  localparam int SLOW = 64;
  localparam int FAST = 4;
  logic clock, srst, supply_valid, osc_running, backup_mode;
  logic below_warn, below_crit, warn_en, crit_en;
  rpc_req_t req;
  logic [7:0] rdata, nv_rd_data, nv_wr_data, trim, quad;
  logic [5:0] turn;
  logic [3:0] trickle, delay;
  logic [1:0] nv_rd_idx, nv_wr_idx, co_sel;
  logic rvalid, nv_rd_req, nv_rd_valid, nv_wr_req, meas_req, meas_done;
  logic scan, co_en, ser_en, th_en, th_per, irq, power_on_flag, ready;
  int cmp_count, miscompares;
  rpc_power_up_nv_config #(.SLOW_TICKS(SLOW), .FAST_TICKS(FAST)) uut (
    .CLOCK(clock), .SRST(srst), .SUPPLY_VALID(supply_valid),
    .OSC_RUNNING(osc_running), .BACKUP_MODE(backup_mode),
    .BELOW_WARN_LEVEL(below_warn), .BELOW_CRIT_LEVEL(below_crit),
    .WARN_IRQ_EN(warn_en), .CRIT_IRQ_EN(crit_en), .REG_REQ(req),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .NV_RD_REQ(nv_rd_req),
    .NV_RD_IDX(nv_rd_idx), .NV_RD_VALID(nv_rd_valid),
    .NV_RD_DATA(nv_rd_data), .NV_WR_REQ(nv_wr_req),
    .NV_WR_IDX(nv_wr_idx), .NV_WR_DATA(nv_wr_data),
    .TEMP_MEAS_REQ(meas_req), .TEMP_MEAS_DONE(meas_done),
    .SCAN_STROBE(scan), .TRICKLE_RES_EN(trickle),
    .CLOCK_OUTPUT_SEL(co_sel), .CLOCK_OUTPUT_EN(co_en),
    .SERIAL_EN(ser_en), .THERMO_EN(th_en), .TEMP_SCAN_PERIOD(th_per),
    .OSC_OFFSET_TRIM(trim), .OSC_QUADRATIC_COEF(quad),
    .OSC_TURNOVER_TEMP(turn), .LOW_SUPPLY_IRQ(irq),
    .POWER_ON_FLAG(power_on_flag), .READY(ready));
  rpc_nv_model partner (
    .CLOCK(clock), .SRST(srst), .DELAY(delay), .NV_RD_REQ(nv_rd_req),
    .NV_RD_IDX(nv_rd_idx), .NV_RD_VALID(nv_rd_valid),
    .NV_RD_DATA(nv_rd_data), .NV_WR_REQ(nv_wr_req),
    .NV_WR_IDX(nv_wr_idx), .NV_WR_DATA(nv_wr_data),
    .TEMP_MEAS_REQ(meas_req), .TEMP_MEAS_DONE(meas_done));
  always #4 clock = ~clock;
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge clock);
  endtask
  task automatic limit(int i, int n);
    if (i >= n) begin
      miscompares++;
      $display("ERROR wait expected done seen timeout");
      results();
    end
  endtask
  // request stays up; caller drops it so back-to-back needs no gap
  task automatic bus(bit wr, logic [5:0] a, logic [7:0] d);
    req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    tick();
  endtask
  task automatic reg_rd(logic [5:0] a, output logic [7:0] d);
    int i;
    bus(1'b0, a, 8'h00);
    req = '0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) tick();
    limit(i, 4);
    d = rdata;
  endtask
  task automatic scan_gap(output int gap);
    int i;
    for (i = 0; i < 200 && scan !== 1'b1; i++) tick();
    limit(i, 200);
    tick();
    for (gap = 1; gap < 200 && scan !== 1'b1; gap++) tick();
  endtask
  task automatic t_hold_reset();
    tick(20);
    `CHK("ready", 1'b0, ready);
    `CHK("nv_rd_req", 1'b0, nv_rd_req);
    `CHK("pon", 1'b0, power_on_flag);
    $display("test hold_reset done");
  endtask
  task automatic t_power_up();
    int i, gap, meas;
    logic [7:0] d;
    below_crit = 1'b1;
    below_warn = 1'b1;
    supply_valid = 1'b1;
    osc_running = 1'b1;
    scan_gap(gap);
    `CHK("fast gap", FAST, gap);
    `CHK("nv_rd_req", 1'b0, nv_rd_req);
    `CHK("pon", 1'b1, power_on_flag);
    below_crit = 1'b0;
    below_warn = 1'b0;
    meas = 0;
    for (i = 0; i < 200 && ready !== 1'b1; i++) begin
      if (meas_req === 1'b1) meas++;
      tick();
    end
    limit(i, 200);
    `CHK("meas", 1, meas);
    `CHK("trickle", 4'ha, trickle);
    `CHK("co_sel", 2'b01, co_sel);
    `CHK("thermo", 2'b11, {th_en, th_per});
    `CHK("trim", 8'hf9, trim);
    `CHK("quad", 8'hff, quad);
    `CHK("turnover", 6'h04, turn);
    reg_rd(ADDR_STATUS, d);
    `CHK("low flags", 2'b00, d[1:0]);
    `CHK("pon bit", 1'b1, d[ST_PON]);
    scan_gap(gap);
    `CHK("slow gap", SLOW, gap);
    $display("test power_up done");
  endtask
  task automatic t_scratch();
    logic [7:0] d;
    for (int a = 0; a < 8; a++) bus(1'b1, ADDR_RAM_BASE + 6'(a),
                                    {4'(a), ~4'(a)});
    req = '0;
    for (int a = 0; a < 8; a++) begin
      reg_rd(ADDR_RAM_BASE + 6'(a), d);
      `CHK("scratch", {4'(a), ~4'(a)}, d);
    end
    bus(1'b1, ADDR_RAM_LAST, 8'h96);
    reg_rd(ADDR_RAM_LAST, d);
    `CHK("scratch back", 8'h96, d);
    reg_rd(6'h20, d);
    `CHK("unmapped", 8'h00, d);
    reg_rd(ADDR_OFS_TRIM, d);
    `CHK("trim read", 8'hf9, d);
    $display("test scratch done");
  endtask
  task automatic t_status_low();
    int i;
    logic [7:0] d;
    bus(1'b1, ADDR_STATUS, 8'h00); // host clears power-on flag
    req = '0;
    tick(2);
    `CHK("pon clear", 1'b0, power_on_flag);
    warn_en = 1'b1;
    below_warn = 1'b1;
    below_crit = 1'b1;
    for (i = 0; i < 200 && irq !== 1'b1; i++) tick();
    limit(i, 200);
    tick(2);
    `CHK("thermo off", 1'b0, th_en);
    reg_rd(ADDR_STATUS, d);
    `CHK("low flags", 2'b11, d[1:0]);
    warn_en = 1'b0;
    tick(3);
    `CHK("irq masked", 1'b0, irq);
    crit_en = 1'b1;
    below_warn = 1'b0;
    below_crit = 1'b0;
    tick(3);
    `CHK("irq crit", 1'b1, irq);
    $display("test status_low done");
  endtask
  task automatic t_backup();
    logic [7:0] d;
    bus(1'b1, ADDR_RAM_BASE, 8'h3c);
    req = '0;
    backup_mode = 1'b1;
    tick(3);
    `CHK("serial", 1'b0, ser_en);
    `CHK("clk out", 1'b0, co_en);
    `CHK("trickle", 4'h0, trickle);
    `CHK("irq", 1'b1, irq);
    bus(1'b1, ADDR_RAM_BASE, 8'hc3);
    req = '0;
    backup_mode = 1'b0;
    // sticky critical flag still gates clock output; host clears both low flags
    bus(1'b1, ADDR_STATUS, 8'h00);
    req = '0;
    tick(3);
    `CHK("irq cleared", 1'b0, irq);
    `CHK("trickle", 4'ha, trickle);
    `CHK("serial", 1'b1, ser_en);
    `CHK("clk out", 1'b1, co_en);
    reg_rd(ADDR_RAM_BASE, d);
    `CHK("scratch", 8'h3c, d);
    $display("test backup done");
  endtask
  task automatic t_nv_write();
    int i;
    // only the config byte; calibration stays untouched
    bus(1'b1, ADDR_NV_CFG, 8'h5a);
    req = '0;
    for (i = 0; i < 8 && nv_wr_req !== 1'b1; i++) tick();
    limit(i, 8);
    `CHK("wr idx", 2'd0, nv_wr_idx);
    `CHK("wr data", 8'h5a, nv_wr_data);
    $display("test nv_write done");
  endtask
  initial begin
    clock = 1'b0;
    srst = 1'b1;
    {supply_valid, osc_running, backup_mode} = 3'b000;
    {below_warn, below_crit, warn_en, crit_en} = 4'h0;
    req = '0;
    delay = 4'h3;
    cmp_count = 0;
    miscompares = 0;
    tick(8);
    srst = 1'b0;
    t_hold_reset();
    t_power_up();
    t_scratch();
    t_status_low();
    t_backup();
    t_nv_write();
    results();
  end
endmodule
`undef CHK
`default_nettype wire
